// >>> inc/retstack_pkg.sv
// constants, types and state layout for the return-stack instruction block
package retstack_pkg;

    // ------------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------------
    localparam int PC_W = 21;
    localparam int INSTR_W = 16;
    localparam int STACK_DEPTH = 31;
    localparam int DEPTH_W = 5;
    localparam int OFFSET_W = 11;

    // ------------------------------------------------------------------
    // opcodes and field positions
    // ------------------------------------------------------------------
    localparam logic [INSTR_W-1:0] OPC_POP = 16'h0006;
    localparam logic [INSTR_W-1:0] OPC_PUSH = 16'h0005;
    localparam logic [INSTR_W-1:0] OPC_SOFT_RESET = 16'h00ff;
    // prefix 1101 followed by a set bit
    localparam logic [4:0] CALL_PREFIX = 5'h1b;
    localparam int CALL_PREFIX_LSB = 11;
    localparam int OFFSET_SIGN = 10;

    // ------------------------------------------------------------------
    // arithmetic constants and reset values
    // ------------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [DEPTH_W-1:0] DEPTH_RST = 5'h00;
    localparam logic [DEPTH_W-1:0] DEPTH_ONE = 5'h01;
    localparam logic [DEPTH_W-1:0] DEPTH_FULL = 5'h1f;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_POP = 3'b001,
        OP_PUSH = 3'b010,
        OP_CALL = 3'b011,
        OP_RESET = 3'b100
    } op_t;

    // ------------------------------------------------------------------
    // whole module state
    // ------------------------------------------------------------------
    typedef struct packed {
        phase_t phase;
        op_t op;
        logic hold;
        logic [INSTR_W-1:0] instr;
        logic [PC_W-1:0] pc;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [DEPTH_W-1:0] depth;
        logic pc_load;
        logic [PC_W-1:0] pc_target;
        logic soft_reset;
    } state_t;

endpackage : retstack_pkg

// >>> rtl/return_stack_ops_exec.sv
// decode and execution of pop, push, relative call and software reset
`timescale 1ns/10ps
`default_nettype none

module return_stack_ops_exec
    import retstack_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_instr_valid,
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic [PC_W-1:0] i_pc,
    output logic [1:0] o_quarter_phase,
    output logic o_fetch_hold,
    output logic [PC_W-1:0] o_stack_top_entry,
    output logic [DEPTH_W-1:0] o_stack_depth,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_target,
    output logic o_soft_reset
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // map an instruction word onto the operations handled here
    function automatic op_t decode_op(input logic [INSTR_W-1:0] w);
        op_t r;
        r = OP_NONE;
        if (w == OPC_POP) begin
            r = OP_POP;
        end else if (w == OPC_PUSH) begin
            r = OP_PUSH;
        end else if (w == OPC_SOFT_RESET) begin
            r = OP_RESET;
        end else if (w[INSTR_W-1:CALL_PREFIX_LSB] == CALL_PREFIX) begin
            r = OP_CALL;
        end
        return r;
    endfunction : decode_op

    // pc of the call plus two plus the doubled signed word offset
    function automatic logic [PC_W-1:0] call_target(
        input logic [PC_W-1:0] pc,
        input logic [INSTR_W-1:0] w
    );
        logic [PC_W-1:0] off2;
        off2 = {{(PC_W-OFFSET_W-1){w[OFFSET_SIGN]}}, w[OFFSET_W-1:0], 1'b0};
        return pc + PC_STEP + off2;
    endfunction : call_target

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam state_t ST_RST = '0;

    state_t st_q;
    state_t st_d;

    // ------------------------------------------------------------------
    // next-state logic, one quarter phase per clock
    // ------------------------------------------------------------------

    // the stack is a shift array: top at index 0, so the top entry is a
    // plain flop and needs no read mux; costs a shift of every entry
    always_comb begin
        st_d = st_q;
        st_d.pc_load = 1'b0;
        st_d.soft_reset = 1'b0;
        if (st_q.soft_reset) begin
            // the core's reset network comes back around to this block
            st_d = ST_RST;
        end else begin
            case (st_q.phase)
                PH_Q1: begin
                    st_d.phase = PH_Q2;
                    st_d.op = OP_NONE;
                    // second cycle of a call decodes nothing
                    if (!st_q.hold && i_instr_valid) begin
                        st_d.op = decode_op(i_instr);
                        st_d.instr = i_instr;
                        st_d.pc = i_pc;
                    end
                end
                PH_Q2: begin
                    st_d.phase = PH_Q3;
                    if (st_q.op == OP_PUSH || st_q.op == OP_CALL) begin
                        // push pc plus two, old top slides down
                        for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                            st_d.stack[i] = st_q.stack[i-1];
                        end
                        st_d.stack[0] = st_q.pc + PC_STEP;
                        if (st_q.depth != DEPTH_FULL) begin
                            st_d.depth = st_q.depth + DEPTH_ONE;
                        end
                    end
                    if (st_q.op == OP_RESET) begin
                        st_d.soft_reset = 1'b1;
                    end
                end
                PH_Q3: begin
                    st_d.phase = PH_Q4;
                    if (st_q.op == OP_POP) begin
                        // old top dropped, never routed to any register
                        for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                            st_d.stack[i] = st_q.stack[i+1];
                        end
                        st_d.stack[STACK_DEPTH-1] = PC_RST;
                        if (st_q.depth != DEPTH_RST) begin
                            st_d.depth = st_q.depth - DEPTH_ONE;
                        end
                    end
                end
                PH_Q4: begin
                    st_d.phase = PH_Q1;
                    st_d.hold = 1'b0;
                    if (st_q.op == OP_CALL) begin
                        // pc written only after the push in q2
                        st_d.pc_load = 1'b1;
                        st_d.pc_target = call_target(st_q.pc, st_q.instr);
                        st_d.hold = 1'b1;
                    end
                end
                default: begin
                    st_d.phase = PH_Q1;
                end
            endcase
        end
    end

    // status flags are owned elsewhere; nothing here can write them

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs are fields of the state flop
    assign o_quarter_phase = st_q.phase;
    assign o_fetch_hold = st_q.hold;
    assign o_stack_top_entry = st_q.stack[0];
    assign o_stack_depth = st_q.depth;
    assign o_pc_load = st_q.pc_load;
    assign o_pc_target = st_q.pc_target;
    assign o_soft_reset = st_q.soft_reset;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence push_q2_s;
        st_q.phase == PH_Q2 && st_q.op == OP_PUSH;
    endsequence

    sequence call_q2_s;
        st_q.phase == PH_Q2 && st_q.op == OP_CALL;
    endsequence

    sequence call_accept_s;
        st_q.phase == PH_Q1 && !st_q.hold && i_instr_valid
            && decode_op(i_instr) == OP_CALL;
    endsequence

    pop_discard_a: assert property (
        (st_q.phase == PH_Q3 && st_q.op == OP_POP)
        |=> o_stack_top_entry == $past(st_q.stack[1])
            && st_q.stack[1] == $past(st_q.stack[2]))
        else $error("pop did not lift the stack by one level");

    pop_depth_a: assert property (
        (st_q.phase == PH_Q3 && st_q.op == OP_POP
            && o_stack_depth != DEPTH_RST)
        |=> o_stack_depth == $past(o_stack_depth) - DEPTH_ONE)
        else $error("pop did not lower stack depth by one");

    push_top_a: assert property (
        push_q2_s |=> o_stack_top_entry == $past(st_q.pc) + PC_STEP)
        else $error("push did not place pc plus two on top");

    push_keep_a: assert property (
        push_q2_s |=> st_q.stack[1] == $past(o_stack_top_entry)
            ##1 st_q.stack[1] == $past(st_q.stack[1]))
        else $error("push lost the previous top entry");

    call_order_a: assert property (
        call_q2_s |-> !o_pc_load
            ##1 (o_stack_top_entry == st_q.pc + PC_STEP && !o_pc_load)
            ##1 !o_pc_load ##1 o_pc_load)
        else $error("call changed pc before pushing return address");

    call_target_a: assert property (
        o_pc_load |-> o_pc_target - st_q.pc == PC_STEP
            + {{(PC_W-OFFSET_W-1){st_q.instr[OFFSET_SIGN]}},
            st_q.instr[OFFSET_W-1:0], 1'b0})
        else $error("call target is not pc plus two plus twice offset");

    call_ret_a: assert property (
        o_pc_load |-> o_stack_top_entry == st_q.pc + PC_STEP)
        else $error("return address does not match call address plus two");

    call_two_a: assert property (
        call_accept_s |-> ##4 (st_q.phase == PH_Q1 && o_fetch_hold)
            ##1 (st_q.op == OP_NONE && o_fetch_hold) ##3 !o_fetch_hold)
        else $error("call did not take exactly two instruction cycles");

    reset_start_a: assert property (
        (st_q.phase == PH_Q2 && st_q.op == OP_RESET)
        |=> o_soft_reset ##1 (o_stack_depth == DEPTH_RST
            && o_stack_top_entry == PC_RST && !o_fetch_hold
            && !o_pc_load && o_pc_target == PC_RST
            && st_q.phase == PH_Q1))
        else $error("software reset did not restore reset state");

    reset_phase_a: assert property (
        $rose(o_soft_reset) |-> $past(st_q.phase) == PH_Q2
            && $past(st_q.op) == OP_RESET)
        else $error("software reset started outside the second quarter");

    stack_mid_a: assert property (
        !$stable(o_stack_depth) |-> $past(st_q.phase) == PH_Q2
            || $past(st_q.phase) == PH_Q3 || $past(o_soft_reset))
        else $error("stack changed outside the middle quarters");

    single_cycle_a: assert property (
        (st_q.phase == PH_Q2 && (st_q.op == OP_PUSH || st_q.op == OP_POP))
        |-> ##3 (st_q.phase == PH_Q1 && !o_fetch_hold && !o_pc_load))
        else $error("push or pop stretched beyond one cycle");

endmodule : return_stack_ops_exec

`default_nettype wire

// >>> sim/return_stack_ops_exec_tb.sv
// self-checking bench for the return-stack instruction block
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// compare helper
// ----------------------------------------------------------------------
`define CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end

module return_stack_ops_exec_tb
    import retstack_pkg::*;
;

    logic i_clk;
    logic i_srst;
    logic i_instr_valid;
    logic [INSTR_W-1:0] i_instr;
    logic [PC_W-1:0] i_pc;
    logic [1:0] o_quarter_phase;
    logic o_fetch_hold;
    logic [PC_W-1:0] o_stack_top_entry;
    logic [DEPTH_W-1:0] o_stack_depth;
    logic o_pc_load;
    logic [PC_W-1:0] o_pc_target;
    logic o_soft_reset;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    // ceiling sized well above the fewer than one hundred cycles the tasks need
    localparam int CYCLE_LIMIT = 5000;

    return_stack_ops_exec DUT (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_instr_valid(i_instr_valid),
        .i_instr(i_instr),
        .i_pc(i_pc),
        .o_quarter_phase(o_quarter_phase),
        .o_fetch_hold(o_fetch_hold),
        .o_stack_top_entry(o_stack_top_entry),
        .o_stack_depth(o_stack_depth),
        .o_pc_load(o_pc_load),
        .o_pc_target(o_pc_target),
        .o_soft_reset(o_soft_reset)
    );

    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // drivers: inputs move on falling edges only
    // ------------------------------------------------------------------
    // step to the falling edge n rising edges later
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask : wait_cyc

    // wait for a take slot, offer the word, return in cycle 1
    task automatic issue(input logic [INSTR_W-1:0] w,
                         input logic [PC_W-1:0] pc);
        while (o_quarter_phase !== 2'h0 || o_fetch_hold !== 1'b0)
            @(negedge i_clk);
        i_instr_valid = 1'b1;
        i_instr = w;
        i_pc = pc;
        wait_cyc(1);
        i_instr_valid = 1'b0;
    endtask : issue

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // two pushes, then pops down past empty
    task automatic push_pop_task();
        issue(OPC_PUSH, 21'h000124);
        `CHK("top before mid", 21'h000000, o_stack_top_entry)
        wait_cyc(1);
        `CHK("top push", 21'h000126, o_stack_top_entry)
        `CHK("depth push", 5'h01, o_stack_depth)
        issue(OPC_PUSH, 21'h0031a0);
        wait_cyc(1);
        `CHK("top push2", 21'h0031a2, o_stack_top_entry)
        `CHK("no pc load", 1'b0, o_pc_load)
        issue(OPC_POP, 21'h014330);
        wait_cyc(1);
        `CHK("top mid pop", 21'h0031a2, o_stack_top_entry)
        wait_cyc(1);
        `CHK("top pop", 21'h000126, o_stack_top_entry)
        `CHK("depth pop", 5'h01, o_stack_depth)
        issue(OPC_POP, 21'h000200);
        wait_cyc(2);
        `CHK("top pop2", 21'h000000, o_stack_top_entry)
        issue(OPC_POP, 21'h000202);
        wait_cyc(2);
        `CHK("depth empty", 5'h00, o_stack_depth)
    endtask : push_pop_task

    // call with offset, a word offered during the no-op cycle is refused
    task automatic call_task(input logic [PC_W-1:0] pc,
                             input logic [OFFSET_W-1:0] off);
        logic [PC_W-1:0] tgt;
        logic [DEPTH_W-1:0] dep;
        tgt = pc + PC_STEP + {{9{off[10]}}, off, 1'b0};
        dep = o_stack_depth + DEPTH_ONE;
        issue({CALL_PREFIX, off}, pc);
        `CHK("pc load early", 1'b0, o_pc_load)
        wait_cyc(1);
        `CHK("call top", pc + PC_STEP, o_stack_top_entry)
        `CHK("call depth", dep, o_stack_depth)
        wait_cyc(2);
        `CHK("pc load", 1'b1, o_pc_load)
        `CHK("pc target", tgt, o_pc_target)
        `CHK("hold", 1'b1, o_fetch_hold)
        i_instr_valid = 1'b1;
        i_instr = OPC_PUSH;
        wait_cyc(1);
        `CHK("pc load pulse", 1'b0, o_pc_load)
        wait_cyc(2);
        `CHK("hold end", 1'b1, o_fetch_hold)
        i_instr_valid = 1'b0;
        wait_cyc(1);
        `CHK("hold free", 1'b0, o_fetch_hold)
        `CHK("refused depth", dep, o_stack_depth)
        `CHK("target holds", tgt, o_pc_target)
    endtask : call_task

    // software reset clears the stack one clock after the pulse
    task automatic reset_task();
        logic [DEPTH_W-1:0] dep;
        dep = o_stack_depth + DEPTH_ONE;
        issue(OPC_PUSH, 21'h000400);
        issue(OPC_SOFT_RESET, 21'h000402);
        `CHK("reset early", 1'b0, o_soft_reset)
        `CHK("depth before reset", dep, o_stack_depth)
        `CHK("top before reset", 21'h000402, o_stack_top_entry)
        wait_cyc(1);
        `CHK("reset pulse", 1'b1, o_soft_reset)
        wait_cyc(1);
        `CHK("reset end", 1'b0, o_soft_reset)
        `CHK("reset depth", DEPTH_RST, o_stack_depth)
        `CHK("reset top", PC_RST, o_stack_top_entry)
        `CHK("reset phase", 2'h0, o_quarter_phase)
        `CHK("reset target", PC_RST, o_pc_target)
        `CHK("reset hold", 1'b0, o_fetch_hold)
    endtask : reset_task

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        i_srst = 1'b1;
        i_instr_valid = 1'b0;
        i_instr = 16'h0000;
        i_pc = 21'h000000;
        repeat (10) @(negedge i_clk);
        i_srst = 1'b0;
        `CHK("depth after reset", DEPTH_RST, o_stack_depth)
        push_pop_task();
        call_task(21'h000100, 11'h400);
        call_task(21'h001000, 11'h3ff);
        reset_task();
        push_pop_task();
        print_verdict();
    end

endmodule : return_stack_ops_exec_tb

`default_nettype wire
